// >>> rtl/timer16_regs.vh
// Purpose: register map and constants for the 16-bit capture/compare timer
// Assumes: axi4-lite, 32-bit data, one aligned word per register
// Notes: offsets and field positions are this block's own map
// Function
// - each valid trig_in_a edge copies timer_count into capcmp_b
// - capture of capcmp_a on the reverse edge raises no match_a_irq
// - preset pair 00 keeps, 01 drives low, 10 drives high, 11 forbidden
// - returning preset pair to 00 keeps the level last forced
// - on start, timer_out begins from the level the preset pair set
// - while running with toggle enabled, timer_out inverts on each capcmp_a compare match, unless a toggling capcmp_b match falls in the same tick
// - first match after start may come one count clock late
// - capture during a read still happens; irq only on valid edges
// - compare/capture contents are undefined once stopped
// - run_mode 01 free-runs, 10 counts from start and clears on each trig_in_a valid edge
// - timer_count equal to capcmp_a in compare mode raises match_a_irq; with toggle enabled it inverts timer_out unless capcmp_b also toggles
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH
`define OFS_MODE    8'h00
`define OFS_CAPCTL  8'h04
`define OFS_OUTCTL  8'h08
`define OFS_PRESC   8'h0c
`define OFS_COUNT   8'h10
`define OFS_CCA     8'h14
`define OFS_CCB     8'h18
`define OFS_IRQ     8'h1c
// mode_ctrl_reg fields
`define MODE_RUN_LO 2
`define MODE_RUN_HI 3
// capture control fields
`define CAP_A_CAPTURE 0
`define CAP_A_REVERSE 1
`define CAP_B_CAPTURE 2
`define CAP_EDGE_LO 4
`define CAP_EDGE_HI 5
// output_ctrl_reg fields
`define OUT_ENABLE 0
`define OUT_TOGGLE_A 1
`define OUT_PRESET_LOW 2
`define OUT_PRESET_HIGH 3
`define OUT_TOGGLE_B 4
// irq register fields
`define IRQ_FLAG_A 0
`define IRQ_FLAG_B 1
`define IRQ_MASK_A 2
`define IRQ_MASK_B 3
// modes
`define RUN_STOP 2'b00
`define RUN_FREE 2'b01
`define RUN_TRIG 2'b10
`define RUN_MATCH 2'b11
// edge select
`define EDGE_FALL 2'b00
`define EDGE_RISE 2'b01
`define EDGE_BOTH 2'b11
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define PRESC_RST 8'h00
`endif

// >>> rtl/edge_detect.v
// Purpose: two-sample edge detector for one trigger input
// Assumes: input synchronous to aclk, sampled on count ticks
// Notes: valid level seen twice in a row forms the edge
`timescale 1ns/1ps
`include "timer16_regs.vh"
module edge_detect (
  input wire aclk,
  input wire aresetn,
  input wire tick,
  input wire enable,
  input wire pin,
  input wire [1:0] edge_sel,
  output wire valid_edge,
  output wire reverse_edge
);
  reg s0_r;
  reg s1_r;
  wire rise;
  wire fall;
  // history cleared while stopped so a restart sees no stale edge
  always @(posedge aclk) begin
    if (!aresetn || !enable) begin
      s0_r <= 1'b0;
      s1_r <= 1'b0;
    end else if (tick) begin
      s0_r <= pin;
      s1_r <= s0_r;
    end
  end
  assign rise = tick & enable & pin & s0_r & ~s1_r;
  assign fall = tick & enable & ~pin & ~s0_r & s1_r;
  assign valid_edge = (edge_sel == `EDGE_BOTH) ? (rise | fall) :
                      (edge_sel == `EDGE_RISE) ? rise :
                      (edge_sel == `EDGE_FALL) ? fall : 1'b0;
  assign reverse_edge = (edge_sel == `EDGE_RISE) ? fall :
                        (edge_sel == `EDGE_FALL) ? rise : 1'b0;
endmodule // edge_detect

// >>> rtl/timer16_capture_compare_output.v
// Purpose: 16-bit timer with two capture/compare registers and toggling output
// Assumes: axi4-lite slave, trigger pins synchronous to aclk
// Notes: count clock is aclk divided by prescaler+1
`timescale 1ns/1ps
`include "timer16_regs.vh"
module timer16_capture_compare_output #(
  parameter WIDTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire trig_in_a,
  input wire trig_in_b,
  output reg timer_out,
  output reg match_a_irq,
  output reg match_b_irq,
  output wire irq_a,
  output wire irq_b
);
  reg [1:0] run_mode_r;
  reg [5:0] capctl_r;
  reg [4:0] outctl_r;
  reg [7:0] presc_r;
  reg [7:0] pcnt_r;
  reg [WIDTH-1:0] timer_count;
  reg [WIDTH-1:0] capcmp_a;
  reg [WIDTH-1:0] capcmp_b;
  reg match_a_irq_flag;
  reg match_b_irq_flag;
  reg match_a_irq_mask;
  reg match_b_irq_mask;
  reg [7:0] awaddr_r;
  reg aw_full_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_full_r;
  reg cap_a_pend_r;
  reg cap_b_pend_r;
  wire tick;
  wire running;
  wire a_valid;
  wire a_rev;
  wire b_valid;
  wire b_rev_unused;
  wire hit_a;
  wire hit_b;
  wire do_wr;
  wire [31:0] wmask;
  wire a_is_cap;
  wire b_is_cap;
  wire out_en;
  wire preset_high;
  wire preset_low;

  function is_addr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      is_addr = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  assign running = (run_mode_r != `RUN_STOP);
  assign tick = running & (pcnt_r == presc_r);
  assign a_is_cap = capctl_r[`CAP_A_CAPTURE];
  assign b_is_cap = capctl_r[`CAP_B_CAPTURE];
  assign out_en = outctl_r[`OUT_ENABLE];
  assign preset_high = outctl_r[`OUT_PRESET_HIGH];
  assign preset_low = outctl_r[`OUT_PRESET_LOW];
  assign hit_a = tick & ~a_is_cap & (timer_count == capcmp_a);
  assign hit_b = tick & ~b_is_cap & (timer_count == capcmp_b);

  edge_detect u_edge_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .enable(running),
    .pin(trig_in_a),
    .edge_sel(capctl_r[`CAP_EDGE_HI:`CAP_EDGE_LO]),
    .valid_edge(a_valid),
    .reverse_edge(a_rev)
  );

  edge_detect u_edge_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .enable(running),
    .pin(trig_in_b),
    .edge_sel(`EDGE_BOTH),
    .valid_edge(b_valid),
    .reverse_edge(b_rev_unused)
  );

  // prescaler; first tick lands up to one count clock late after start
  always @(posedge aclk) begin
    if (!aresetn || !running)
      pcnt_r <= 8'h00;
    else if (pcnt_r == presc_r)
      pcnt_r <= 8'h00;
    else
      pcnt_r <= pcnt_r + 8'h01;
  end

  // axi write channel: address and data taken in either order
  assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_r & ~s_axi_bvalid;
  assign do_wr = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r > `OFS_IRQ + 8'h03) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_mode_r <= `RUN_STOP;
      capctl_r <= 6'h00;
      outctl_r <= 5'h00;
      presc_r <= `PRESC_RST;
    end else if (do_wr) begin
      if (is_addr(awaddr_r, `OFS_MODE))
        run_mode_r <= ((wdata_r[3:2] & wmask[3:2]) | (run_mode_r & ~wmask[3:2]));
      if (is_addr(awaddr_r, `OFS_CAPCTL) && !running && wstrb_r[0])
        capctl_r <= wdata_r[5:0];
      if (is_addr(awaddr_r, `OFS_OUTCTL) && wstrb_r[0]) begin
        outctl_r[`OUT_ENABLE] <= wdata_r[`OUT_ENABLE];
        outctl_r[`OUT_TOGGLE_A] <= wdata_r[`OUT_TOGGLE_A];
        outctl_r[`OUT_TOGGLE_B] <= wdata_r[`OUT_TOGGLE_B];
        // preset pair honoured only while stopped
        if (!running) begin
          outctl_r[`OUT_PRESET_LOW] <= wdata_r[`OUT_PRESET_LOW];
          outctl_r[`OUT_PRESET_HIGH] <= wdata_r[`OUT_PRESET_HIGH];
        end
      end
      if (is_addr(awaddr_r, `OFS_PRESC) && wstrb_r[0] && !running)
        presc_r <= wdata_r[7:0];
    end
  end

  // counter: trigger clear, increment, clear on capcmp_a in match mode
  always @(posedge aclk) begin
    if (!aresetn || !running)
      timer_count <= {WIDTH{1'b0}};
    else if (run_mode_r == `RUN_TRIG && a_valid)
      timer_count <= {WIDTH{1'b0}};
    else if (run_mode_r == `RUN_MATCH && hit_a)
      timer_count <= {WIDTH{1'b0}};
    else if (tick)
      timer_count <= timer_count + 1'b1;
  end

  // capture/compare registers; a capture is never blocked by a bus read
  always @(posedge aclk) begin
    if (!aresetn) begin
      capcmp_a <= {WIDTH{1'b0}};
      capcmp_b <= {WIDTH{1'b0}};
    end else begin
      if (do_wr && is_addr(awaddr_r, `OFS_CCA) && !a_is_cap)
        capcmp_a <= (wdata_r[WIDTH-1:0] & wmask[WIDTH-1:0]) | (capcmp_a & ~wmask[WIDTH-1:0]);
      if (do_wr && is_addr(awaddr_r, `OFS_CCB) && !b_is_cap)
        capcmp_b <= (wdata_r[WIDTH-1:0] & wmask[WIDTH-1:0]) | (capcmp_b & ~wmask[WIDTH-1:0]);
      // capcmp_a: trig_in_b edge, or reverse edge of trig_in_a
      if (a_is_cap && (capctl_r[`CAP_A_REVERSE] ? a_rev : b_valid))
        capcmp_a <= timer_count;
      if (b_is_cap && a_valid)
        capcmp_b <= timer_count;
    end
  end

  // irq pulse one aclk cycle after capture, as captures land before the interrupt
  always @(posedge aclk) begin
    if (!aresetn) begin
      cap_a_pend_r <= 1'b0;
      cap_b_pend_r <= 1'b0;
      match_a_irq <= 1'b0;
      match_b_irq <= 1'b0;
    end else begin
      // reverse-phase capture never raises the irq; trig_in_b still does
      cap_a_pend_r <= a_is_cap & b_valid;
      cap_b_pend_r <= b_is_cap & a_valid;
      match_a_irq <= hit_a | cap_a_pend_r;
      match_b_irq <= hit_b | cap_b_pend_r;
    end
  end

  // sticky flags, set wins over software clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      match_a_irq_flag <= 1'b0;
      match_b_irq_flag <= 1'b0;
      match_a_irq_mask <= 1'b1;
      match_b_irq_mask <= 1'b1;
    end else begin
      if (do_wr && is_addr(awaddr_r, `OFS_IRQ) && wstrb_r[0]) begin
        match_a_irq_flag <= wdata_r[`IRQ_FLAG_A];
        match_b_irq_flag <= wdata_r[`IRQ_FLAG_B];
        match_a_irq_mask <= wdata_r[`IRQ_MASK_A];
        match_b_irq_mask <= wdata_r[`IRQ_MASK_B];
      end
      if (match_a_irq)
        match_a_irq_flag <= 1'b1;
      if (match_b_irq)
        match_b_irq_flag <= 1'b1;
    end
  end
  assign irq_a = match_a_irq_flag & ~match_a_irq_mask;
  assign irq_b = match_b_irq_flag & ~match_b_irq_mask;

  // output flip-flop: preset while stopped, toggle on matches while running
  always @(posedge aclk) begin
    if (!aresetn)
      timer_out <= 1'b0;
    else if (!running) begin
      if (preset_high && !preset_low)
        timer_out <= 1'b1;
      else if (preset_low && !preset_high)
        timer_out <= 1'b0;
      // 00 and the forbidden 11 leave the level alone
    end else if (out_en) begin
      // starts from the preset level since nothing reloads it at start
      if ((hit_a && outctl_r[`OUT_TOGGLE_A]) ^ (hit_b && outctl_r[`OUT_TOGGLE_B]))
        timer_out <= ~timer_out;
    end
  end

  // read channel, one-cycle answer; values undefined once stopped
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      if (is_addr(s_axi_araddr, `OFS_MODE))
        s_axi_rdata <= {28'h0000000, run_mode_r, 2'b00};
      else if (is_addr(s_axi_araddr, `OFS_CAPCTL))
        s_axi_rdata <= {26'h0, capctl_r};
      else if (is_addr(s_axi_araddr, `OFS_OUTCTL))
        s_axi_rdata <= {26'h0, timer_out, outctl_r};
      else if (is_addr(s_axi_araddr, `OFS_PRESC))
        s_axi_rdata <= {24'h000000, presc_r};
      else if (is_addr(s_axi_araddr, `OFS_COUNT))
        s_axi_rdata <= {{(32-WIDTH){1'b0}}, timer_count};
      else if (is_addr(s_axi_araddr, `OFS_CCA))
        s_axi_rdata <= {{(32-WIDTH){1'b0}}, capcmp_a};
      else if (is_addr(s_axi_araddr, `OFS_CCB))
        s_axi_rdata <= {{(32-WIDTH){1'b0}}, capcmp_b};
      else if (is_addr(s_axi_araddr, `OFS_IRQ))
        s_axi_rdata <= {28'h0000000, match_b_irq_mask, match_a_irq_mask,
                        match_b_irq_flag, match_a_irq_flag};
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // timer16_capture_compare_output

// >>> testbench/trig_source.sv
// Purpose: far-side pulse source driving the first trigger pin
// Assumes: pulse width in aclk cycles, two or more
// Notes: a fire request during a pulse is dropped
`timescale 1ns/1ps
module trig_source (
  input wire aclk,
  input wire fire,
  input wire [7:0] width,
  output reg trig_in_a
);
  reg [7:0] left_r = 8'h00;
  initial trig_in_a = 1'b0;
  always @(posedge aclk) begin
    if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
      trig_in_a <= left_r != 8'h01;
    end else if (fire) begin
      left_r <= width;
      trig_in_a <= 1'b1;
    end
  end
endmodule // trig_source

// >>> testbench/timer16_assertions.sv
// Purpose: port-level checks for the capture/compare timer
// Assumes: run mode and toggle enable shadowed from bus writes
// Notes: shadow leads the design by a cycle, bounds allow it
`timescale 1ns/1ps
module timer16_checker (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire timer_out,
  input wire match_a_irq,
  input wire match_b_irq
);
  wire wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire wr_out = wr && s_axi_awaddr == 8'h08;
  wire [1:0] pre = s_axi_wdata[3:2];
  reg [1:0] run_r;
  reg tog_a_r;
  reg [3:0] stop_cnt_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_r <= 2'b00;
      tog_a_r <= 1'b0;
      stop_cnt_r <= 4'h0;
    end else begin
      if (wr && s_axi_awaddr == 8'h00)
        run_r <= s_axi_wdata[3:2];
      if (wr_out)
        tog_a_r <= s_axi_wdata[1];
      if (run_r != 2'b00)
        stop_cnt_r <= 4'h0;
      else if (stop_cnt_r != 4'hf)
        stop_cnt_r <= stop_cnt_r + 4'h1;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_a_pulse; match_a_irq |=> !match_a_irq; endproperty
  a_a_pulse: assert property (p_a_pulse)
    else $error("match_a_irq wider than one cycle");
  property p_b_pulse; match_b_irq |=> !match_b_irq; endproperty
  a_b_pulse: assert property (p_b_pulse)
    else $error("match_b_irq wider than one cycle");
  property p_set_hi; wr_out && pre == 2'b10 && s_axi_wdata[0] |-> ##[1:3] timer_out; endproperty
  a_set_hi: assert property (p_set_hi)
    else $error("preset high not applied");
  property p_set_lo; wr_out && pre == 2'b01 && s_axi_wdata[0] |-> ##[1:3] !timer_out; endproperty
  a_set_lo: assert property (p_set_lo)
    else $error("preset low not applied");
  property p_hold;
    stop_cnt_r > 4'h2 && $changed(timer_out) |-> $past(wr_out, 3);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stopped output changed without a write");
  property p_tog_a; match_a_irq && tog_a_r |-> timer_out != $past(timer_out, 3); endproperty
  a_tog_a: assert property (p_tog_a)
    else $error("output not inverted on compare match");
  property p_start; $rose(run_r != 2'b00) |=> $stable(timer_out) [*3]; endproperty
  a_start: assert property (p_start)
    else $error("output moved at start");
  property p_quiet; stop_cnt_r > 4'h4 |-> !match_a_irq && !match_b_irq; endproperty
  a_quiet: assert property (p_quiet)
    else $error("match pulse while stopped");
  c_toggle: cover property (match_a_irq && tog_a_r);
  c_capture: cover property (match_b_irq && run_r != 2'b00);
  c_preset: cover property (wr_out && pre == 2'b01);
endmodule // timer16_checker
bind timer16_capture_compare_output timer16_checker chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .timer_out, .match_a_irq, .match_b_irq);

// >>> testbench/tb_top.sv
// Purpose: self-checking bench for the capture/compare timer
// Assumes: prescaler left at 0, one count tick per aclk
// Notes: bus tasks sample handshakes at the rising edge
`timescale 1ns/1ps
module tb_top;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  reg fire = 1'b0;
  reg [1:0] rr;
  reg [1:0] br;
  reg trig_b = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, trig_a;
  wire [31:0] rdata;
  wire [1:0] rresp;
  wire [1:0] bresp;
  wire timer_out, match_a_irq, match_b_irq, irq_a, irq_b;
  integer fails = 0;
  integer n_checks = 0;
  integer na = 0;
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk)
    if (match_a_irq === 1'b1) na = na + 1;
  trig_source src (.aclk(aclk), .fire(fire), .width(8'h06), .trig_in_a(trig_a));
  timer16_capture_compare_output uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig_in_a(trig_a), .trig_in_b(trig_b),
    .timer_out(timer_out), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq),
    .irq_a(irq_a), .irq_b(irq_b));
  task results;
    begin
      if (fails == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // each channel released at the edge that takes it, response taken at its own edge
  task wr(input [7:0] a, input [31:0] d);
    reg done;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (awvalid && awready)
          awvalid <= 1'b0;
        if (wvalid && wready)
          wvalid <= 1'b0;
        if (bready && bvalid) begin
          br = bresp;
          bready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    reg done;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      d = 32'h0;
      while (!done) begin
        @(posedge aclk);
        if (arvalid && arready)
          arvalid <= 1'b0;
        if (rready && rvalid) begin
          d = rdata;
          rr = rresp;
          rready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
  // bounded wait for a match pulse, n counts cycles
  task wait_irq(input b, output integer n);
    begin
      n = 0;
      @(negedge aclk);
      while ((b ? match_b_irq : match_a_irq) !== 1'b1 && n < 200) begin
        @(negedge aclk);
        n = n + 1;
      end
    end
  endtask
  task t_preset;
    reg [47:0] dat;
    reg [5:0] lvl;
    reg [31:0] r;
    integer i;
    begin
      dat = 48'h09_01_05_01_09_0d;
      lvl = 6'b110011;
      for (i = 5; i >= 0; i = i - 1) begin
        wr(8'h08, {24'h0, dat[8*i +: 8]});
        repeat (3) @(negedge aclk);
        cmp(timer_out, lvl[i]);
      end
      cmp(br, 2'b00);
      rd(8'h08, r);
      cmp(r[5], 1'b1);
      rd(8'h40, r);
      cmp(r, 32'h0);
      cmp(rr, 2'b10);
      wr(8'h40, 32'h0);
      cmp(br, 2'b10);
    end
  endtask
  task t_toggle;
    integer n;
    reg [31:0] r;
    begin
      wr(8'h14, 32'h14);
      wr(8'h08, 32'h3);
      wr(8'h00, 32'h4);
      cmp(timer_out, 1'b1);
      wait_irq(1'b0, n);
      cmp(n >= 18 && n <= 23, 1'b1);
      cmp(timer_out, 1'b0);
      rd(8'h10, r);
      cmp(r >= 20 && r <= 26, 1'b1);
      wr(8'h00, 32'h0);
      rd(8'h10, r);
      cmp(r, 32'h0);
      cmp(timer_out, 1'b0);
    end
  endtask
  task t_capture;
    integer n, m;
    reg [31:0] ra, rb;
    begin
      wr(8'h08, 32'h0);
      wr(8'h04, 32'h17);
      wr(8'h00, 32'h4);
      m = na;
      repeat (30) @(posedge aclk);
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      wait_irq(1'b1, n);
      cmp(n < 8, 1'b1);
      repeat (12) @(negedge aclk);
      rd(8'h14, ra);
      rd(8'h18, rb);
      cmp(ra - rb, 32'h6);
      cmp(rb > 28 && rb < 40, 1'b1);
      cmp(na, m);
      // trig_in_b edge still interrupts while capcmp_a uses the reverse edge
      @(posedge aclk);
      trig_b <= 1'b1;
      repeat (8) @(posedge aclk);
      cmp(na, m + 1);
      wr(8'h00, 32'h0);
      trig_b <= 1'b0;
    end
  endtask
  task t_duty;
    integer n;
    begin
      wr(8'h04, 32'h0);
      wr(8'h14, 32'h28);
      wr(8'h18, 32'h0a);
      wr(8'h08, 32'h13);
      wr(8'h00, 32'hc);
      wait_irq(1'b1, n);
      wr(8'h1c, 32'hc);
      wr(8'h08, 32'h3);
      wr(8'h18, 32'h19);
      repeat (2) @(posedge aclk);
      wr(8'h08, 32'h13);
      wr(8'h1c, 32'hc);
      wr(8'h1c, 32'h4);
      cmp(irq_b, 1'b0);
      wait_irq(1'b1, n);
      wait_irq(1'b0, n);
      cmp(n >= 14 && n <= 16, 1'b1);
      cmp(irq_b, 1'b1);
      wr(8'h1c, 32'h1);
      cmp(irq_a, 1'b1);
      cmp(irq_b, 1'b0);
      wr(8'h00, 32'h0);
    end
  endtask
  initial begin
    #40000;
    fails = fails + 1;
    results;
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_preset;
    t_toggle;
    t_capture;
    t_duty;
    results;
  end
endmodule // tb_top
